/* File: rtl/eeprom_pkg.sv */
// shared constants, types and enums of the serial eeprom command port
package eeprom_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SELECT_LOW_TIME_NS = 250;
  localparam int SELECT_LOW_CYCLES =
    (SELECT_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_MS = 6;
  localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================
  // array and frame layout
  localparam int WORDS = 64;
  typedef logic [4:0] count_t;
  localparam count_t HDR_BITS_X8 = 5'h09;
  localparam count_t HDR_BITS_X16 = 5'h08;
  localparam count_t DATA_BITS_X8 = 5'h08;
  localparam count_t DATA_BITS_X16 = 5'h10;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ==========================================================
  // opcodes and extended codes (top address bits under opcode 00)
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;

  // ==========================================================
  // organization variants
  localparam logic [1:0] WIDTH_PIN = 2'h0;
  localparam logic [1:0] WIDTH_FIXED8 = 2'h1;
  localparam logic [1:0] WIDTH_FIXED16 = 2'h2;

  // ==========================================================
  // types
  typedef struct packed {
    logic select;
    logic sclk;
    logic din;
    logic wsel;
  } link_s;

  typedef enum logic [1:0] {
    PROG_ERASE,
    PROG_ERASE_ALL,
    PROG_WRITE,
    PROG_WRITE_ALL
  } prog_e;

  typedef enum logic [2:0] {
    ST_WAIT,
    ST_HDR,
    ST_DATA,
    ST_READ,
    ST_ARMED
  } state_e;

endpackage

/* File: rtl/link_sync.sv */
// two-flop synchroniser and edge finder for the link pins
`timescale 1ns/1ps
module link_sync
  import eeprom_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire link_s pins,
  output link_s level,
  output link_s rise,
  output link_s fall
);

  // ==========================================================
  // synchroniser
  link_s s1;
  link_s s2;
  link_s s3;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ==========================================================
  // edges come from the second and third stage only
  assign level = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;

endmodule

/* File: rtl/prog_timer.sv */
// self-timed programming cycle counter
`timescale 1ns/1ps
module prog_timer #(
  parameter int CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);

  // ==========================================================
  // countdown, needs no serial clock at all
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        cnt <= LOAD;
      end else if (busy) begin
        if (cnt == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end

endmodule

/* File: rtl/eeprom_port.sv */
// serial eeprom device: command decoder, array, read-out and status
//
// Notes on behaviour
// - erase-all sets every array bit to one, same cycle as word erase
// - erase-all starts at select fall, or last clock on fast variant
// - status driven after select rises from long enough low phase
// - start bit then select low clears status after cycle ends
// - powers up disabled; erase and write refused until enable
// - enable holds until disable command or power removal
// - read works whether programming enabled or not
// - read gives dummy zero then 8 or 16 data bits
// - read output changes on each serial clock rise
// - select held high keeps reading following addresses
// - write carries 8/16 data bits; cycle starts at select fall, or last clock on fast variant
// - write-all fills every word, auto-erase, only when enabled
// - programming cycle completes with no serial clocks
// - select low resets control logic; running cycle still finishes
// - input bits captured on serial clock rise
// - serial clock may pause at either level mid transfer
// - clocks ignored while deselected or before a start bit
// - exact clock count executes; then wait for new start bit
// - status floats if select low whole cycle; later check high
// - width_select high gives 16-bit words, low gives 8-bit
// - start bit is first clock rise with select and data high outside a programming cycle
// - opcodes 10 read, 01 write, 11 erase, 00 extended codes
// - output floats except read or status; floats at select fall
// - word erase sets addressed word to all ones, self-timed
`timescale 1ns/1ps
module eeprom_port
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLE_COUNT = PROG_CYCLES,
  parameter bit FAST_START = 1'b0,
  parameter logic [1:0] WIDTH_MODE = WIDTH_PIN
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CHIP_SELECT,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_IN,
  input wire logic WIDTH_SELECT,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE_N,
  output logic BUSY,
  output logic PROGRAM_ENABLED
);

  // ==========================================================
  // pin sampling
  link_s pins;
  link_s lv;
  link_s rise;
  link_s fall;

  assign pins = '{select: CHIP_SELECT, sclk: SERIAL_CLK,
                  din: SERIAL_IN, wsel: WIDTH_SELECT};

  // pins cross into the system clock before anything reads them
  link_sync u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .pins(pins),
    .level(lv),
    .rise(rise),
    .fall(fall)
  );

  // ==========================================================
  // storage and decode helpers
  logic [15:0] mem [WORDS];
  logic w16;
  state_e state;
  logic [15:0] sr;
  count_t nbits;

  function automatic logic [1:0] op_of(logic [15:0] s, logic wide);
    return wide ? s[7:6] : s[8:7];
  endfunction

  function automatic logic [1:0] ext_of(logic [15:0] s, logic wide);
    return wide ? s[5:4] : s[6:5];
  endfunction

  function automatic logic [6:0] addr_of(logic [15:0] s, logic wide);
    return wide ? {1'b0, s[5:0]} : s[6:0];
  endfunction

  // byte address in x8: even byte sits in the upper half of a word
  function automatic logic [15:0] word_at(logic [6:0] a, logic wide);
    logic [15:0] w;
    w = wide ? mem[a[5:0]] : mem[a[6:1]];
    if (wide)
      return w;
    return a[0] ? {w[7:0], 8'h00} : {w[15:8], 8'h00};
  endfunction

  function automatic logic [6:0] addr_inc(logic [6:0] a, logic wide);
    logic [6:0] n;
    n = a + 7'h01;
    return wide ? {1'b0, n[5:0]} : n;
  endfunction

  // ==========================================================
  // clock events and frame decode
  logic width_now;
  logic clk_ev;
  logic [15:0] next_sr;
  count_t nbits_inc;
  count_t hdr_len;
  count_t data_len;
  logic hdr_done;
  logic data_done;
  logic [1:0] op;
  logic [1:0] ext;
  logic [6:0] addr;
  logic start_ok;
  logic prog_busy;
  logic prog_done;
  logic enabled;
  logic prog_cmd;
  logic prog_go;

  always_comb begin
    case (WIDTH_MODE)
      WIDTH_FIXED8: width_now = 1'b0;
      WIDTH_FIXED16: width_now = 1'b1;
      default: width_now = lv.wsel;
    endcase
  end

  // deselected clocks are never events
  assign clk_ev = rise.sclk & lv.select;
  assign next_sr = {sr[14:0], lv.din};
  assign nbits_inc = nbits + 5'h01;
  assign hdr_len = w16 ? HDR_BITS_X16 : HDR_BITS_X8;
  assign data_len = w16 ? DATA_BITS_X16 : DATA_BITS_X8;
  assign hdr_done = state == ST_HDR && nbits_inc == hdr_len;
  assign data_done = state == ST_DATA && nbits_inc == data_len;
  assign op = op_of(next_sr, w16);
  assign ext = ext_of(next_sr, w16);
  assign addr = addr_of(next_sr, w16);
  // a new frame is not taken while the array is being programmed
  assign start_ok = state == ST_WAIT && lv.din && !prog_busy;
  assign prog_cmd = op == OP_ERASE ||
                    (op == OP_EXT && ext == EXT_ERASE_ALL);

  // ==========================================================
  // frame state machine
  prog_e pend_op;
  logic [6:0] pend_addr;
  logic [15:0] pend_data;
  logic pend_w16;

  always_ff @(posedge CLK_SYS) begin
    if (RST || !lv.select) begin
      state <= ST_WAIT;
      nbits <= '0;
      sr <= '0;
    end else if (clk_ev) begin
      // paused clocks simply produce no event
      case (state)
        ST_WAIT: begin
          if (start_ok) begin
            state <= ST_HDR;
            nbits <= '0;
            sr <= '0;
            w16 <= width_now;
          end
        end
        ST_HDR: begin
          sr <= next_sr;
          nbits <= nbits_inc;
          if (hdr_done) begin
            nbits <= '0;
            pend_addr <= addr;
            pend_w16 <= w16;
            state <= ST_WAIT;
            if (op == OP_READ) begin
              state <= ST_READ;
            end else if (op == OP_WRITE ||
                         (op == OP_EXT && ext == EXT_WRITE_ALL)) begin
              // data bits are always taken, so none can pose as a start
              state <= ST_DATA;
              pend_op <= op == OP_WRITE ? PROG_WRITE : PROG_WRITE_ALL;
            end else if (prog_cmd) begin
              if (enabled && !FAST_START)
                state <= ST_ARMED;
              pend_op <= op == OP_ERASE ? PROG_ERASE : PROG_ERASE_ALL;
            end
          end
        end
        ST_DATA: begin
          sr <= next_sr;
          nbits <= nbits_inc;
          if (data_done) begin
            pend_data <= w16 ? next_sr : {8'h00, next_sr[7:0]};
            if (!enabled || FAST_START)
              state <= ST_WAIT;
            else
              state <= ST_ARMED;
          end
        end
        ST_READ: state <= ST_READ;
        ST_ARMED: state <= ST_ARMED;
        default: state <= ST_WAIT;
      endcase
    end
  end

  // ==========================================================
  // programming start and the self-timed cycle
  // slow parts start on select fall, fast parts on the last clock
  assign prog_go = (state == ST_ARMED && fall.select) ||
    (FAST_START && clk_ev && enabled &&
     ((hdr_done && prog_cmd) || data_done));

  prog_timer #(.CYCLES(PROG_CYCLE_COUNT)) u_timer (
    .clk(CLK_SYS),
    .rst(RST),
    .start(prog_go),
    .busy(prog_busy),
    .done(prog_done)
  );

  // ==========================================================
  // enable latch; only reset or the disable command clears it
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      enabled <= 1'b0;
    end else if (clk_ev && hdr_done && op == OP_EXT) begin
      if (ext == EXT_ENABLE)
        enabled <= 1'b1;
      else if (ext == EXT_DISABLE)
        enabled <= 1'b0;
    end
  end

  // ==========================================================
  // array update, only once the cycle has expired
  logic [15:0] fill;

  // x8 fill repeats the byte so both halves of each word match
  assign fill = pend_w16 ? pend_data : {pend_data[7:0], pend_data[7:0]};

  always_ff @(posedge CLK_SYS) begin
    if (prog_done) begin
      case (pend_op)
        PROG_ERASE_ALL: begin
          for (int i = 0; i < WORDS; i++)
            mem[i] <= ERASED_WORD;
        end
        PROG_WRITE_ALL: begin
          for (int i = 0; i < WORDS; i++)
            mem[i] <= fill;
        end
        PROG_ERASE: begin
          if (pend_w16)
            mem[pend_addr[5:0]] <= ERASED_WORD;
          else if (pend_addr[0])
            mem[pend_addr[6:1]][7:0] <= ERASED_WORD[7:0];
          else
            mem[pend_addr[6:1]][15:8] <= ERASED_WORD[15:8];
        end
        PROG_WRITE: begin
          if (pend_w16)
            mem[pend_addr[5:0]] <= pend_data;
          else if (pend_addr[0])
            mem[pend_addr[6:1]][7:0] <= pend_data[7:0];
          else
            mem[pend_addr[6:1]][15:8] <= pend_data[7:0];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sequential read-out shifter
  logic [15:0] rd_cur;
  count_t rd_cnt;
  logic [6:0] rd_addr;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_cur <= '0;
      rd_cnt <= '0;
      rd_addr <= '0;
    end else if (clk_ev && hdr_done && op == OP_READ) begin
      rd_addr <= addr;
      rd_cur <= word_at(addr, w16);
      rd_cnt <= data_len;
    end else if (clk_ev && state == ST_READ) begin
      if (rd_cnt == 5'h01) begin
        rd_addr <= addr_inc(rd_addr, w16);
        rd_cur <= word_at(addr_inc(rd_addr, w16), w16);
        rd_cnt <= data_len;
      end else begin
        rd_cur <= {rd_cur[14:0], 1'b0};
        rd_cnt <= rd_cnt - 5'h01;
      end
    end
  end

  // ==========================================================
  // status tracking
  logic pend_status;
  logic start_seen;
  logic show;
  logic [3:0] low_cnt;
  localparam logic [3:0] LOW_MIN = 4'(SELECT_LOW_CYCLES);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      low_cnt <= '0;
    end else if (lv.select) begin
      low_cnt <= '0;
    end else if (low_cnt != LOW_MIN) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pend_status <= 1'b0;
      start_seen <= 1'b0;
      show <= 1'b0;
    end else begin
      if (fall.select) begin
        start_seen <= 1'b0;
        show <= 1'b0;
        if (start_seen && !prog_busy)
          pend_status <= 1'b0;
      end else if (clk_ev && start_ok) begin
        start_seen <= 1'b1;
        show <= 1'b0;
      end else if (rise.select && pend_status && low_cnt == LOW_MIN) begin
        show <= 1'b1;
      end
      // a new cycle wins over a clear in the same cycle
      if (prog_go)
        pend_status <= 1'b1;
    end
  end

  // ==========================================================
  // output pin drive
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SERIAL_OUT <= 1'b1;
      SERIAL_OUT_OE_N <= 1'b1;
    end else if (!lv.select) begin
      SERIAL_OUT_OE_N <= 1'b1;
    end else if (clk_ev && hdr_done && op == OP_READ) begin
      SERIAL_OUT <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b0;
    end else if (state == ST_READ) begin
      if (clk_ev)
        SERIAL_OUT <= rd_cur[15];
      SERIAL_OUT_OE_N <= 1'b0;
    end else if (show) begin
      // after an unwatched cycle this shows ready
      SERIAL_OUT <= !prog_busy;
      SERIAL_OUT_OE_N <= 1'b0;
    end else begin
      SERIAL_OUT_OE_N <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      BUSY <= 1'b0;
      PROGRAM_ENABLED <= 1'b0;
    end else begin
      BUSY <= prog_busy;
      PROGRAM_ENABLED <= enabled;
    end
  end

endmodule

/* File: sim/eeprom_port_asserts.sv */
// assertion checker for the serial eeprom command port
`timescale 1ns/1ps
module eeprom_port_asserts #(
  parameter int PROG_CYCLE_COUNT = 16
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CHIP_SELECT,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_IN,
  input wire logic WIDTH_SELECT,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE_N,
  input wire logic BUSY,
  input wire logic PROGRAM_ENABLED
);
  // ==========
  // helper logic
  logic [31:0] busy_cnt;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      busy_cnt <= 32'h0;
    end else begin
      busy_cnt <= BUSY ? busy_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence cs_idle;
    !CHIP_SELECT [*6];
  endsequence
  // sync stages delay any change, so a long quiet span must be still
  sequence out_quiet;
    (CHIP_SELECT && !SERIAL_CLK && !BUSY) [*8];
  endsequence
  // ==========
  // properties
  reset_state_a: assert property (
    $fell(RST) |-> !BUSY && !PROGRAM_ENABLED && SERIAL_OUT_OE_N)
    else $error("outputs not at reset state");
  busy_length_a: assert property (
    $fell(BUSY) |-> busy_cnt == 32'(PROG_CYCLE_COUNT))
    else $error("busy span differs from cycle count");
  busy_enabled_a: assert property (
    $rose(BUSY) |-> PROGRAM_ENABLED)
    else $error("cycle started while disabled");
  busy_start_a: assert property (
    $rose(BUSY) |-> !CHIP_SELECT && !$past(CHIP_SELECT, 2))
    else $error("cycle started before select fell");
  float_fall_a: assert property (
    $fell(CHIP_SELECT) |-> ##[1:5] SERIAL_OUT_OE_N)
    else $error("output not floated after select fall");
  idle_float_a: assert property (
    cs_idle |-> SERIAL_OUT_OE_N)
    else $error("output driven while deselected");
  enable_hold_a: assert property (
    cs_idle |=> $stable(PROGRAM_ENABLED))
    else $error("enable state moved while deselected");
  status_busy_a: assert property (
    BUSY && $past(BUSY) && !SERIAL_OUT_OE_N |-> !SERIAL_OUT)
    else $error("status shows ready while busy");
  out_quiet_a: assert property (
    out_quiet |-> $stable(SERIAL_OUT))
    else $error("output moved with no clock edge");
endmodule

bind eeprom_port eeprom_port_asserts #(
  .PROG_CYCLE_COUNT(PROG_CYCLE_COUNT)
) chk (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .CHIP_SELECT(CHIP_SELECT),
  .SERIAL_CLK(SERIAL_CLK),
  .SERIAL_IN(SERIAL_IN),
  .WIDTH_SELECT(WIDTH_SELECT),
  .SERIAL_OUT(SERIAL_OUT),
  .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
  .BUSY(BUSY),
  .PROGRAM_ENABLED(PROGRAM_ENABLED)
);

/* File: sim/host_link.sv */
// host model driving the three-wire link of the eeprom
`timescale 1ns/1ps
module host_link (
  input wire logic clk,
  output logic cs,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic oe_n
);
  event got;
  logic got_v;
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
    din = 1'b0;
  end
  // ==========
  // timing helpers
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic see(input logic v);
    got_v = v;
    -> got;
    #1;
  endtask
  // 400 ns period: four system cycles low, four high
  task automatic bit1(input logic b);
    din = b;
    wt(4);
    sclk = 1'b1;
    wt(4);
    sclk = 1'b0;
  endtask
  // ==========
  // link operations
  task automatic cmd(input logic [31:0] v, input int n);
    cs = 1'b1; // clock is low as select rises
    for (int i = n - 1; i >= 0; i--) begin
      bit1(v[i]);
    end
  endtask
  task automatic drop();
    cs = 1'b0;
    din = ~din; // no stale level left on the line
    wt(6);
  endtask
  task automatic rd(input int n);
    wt(2);
    see(dout);
    for (int i = 0; i < n; i++) begin
      bit1(1'b0);
      wt(2);
      see(dout);
    end
  endtask
  task automatic show();
    cs = 1'b1;
    wt(6);
    see(oe_n);
    see(dout);
  endtask
endmodule

/* File: sim/eeprom_port_tb.sv */
// self-checking bench for the serial eeprom command port
`timescale 1ns/1ps
module eeprom_port_tb;
  import eeprom_pkg::*;
  localparam int CYC = 50;
  logic clk_sys, rst, width_select, cs, sclk, din;
  logic serial_out, serial_out_oe_n, busy, program_enabled;
  logic exp_q[$];
  int num_errors, checks_done;
  logic [31:0] seed;
  logic [15:0] mem [64];
  logic [15:0] d;
  logic [5:0] a;
  eeprom_port #(
    .PROG_CYCLE_COUNT(CYC)
  ) DUT (
    .CLK_SYS(clk_sys),
    .RST(rst),
    .CHIP_SELECT(cs),
    .SERIAL_CLK(sclk),
    .SERIAL_IN(din),
    .WIDTH_SELECT(width_select),
    .SERIAL_OUT(serial_out),
    .SERIAL_OUT_OE_N(serial_out_oe_n),
    .BUSY(busy),
    .PROGRAM_ENABLED(program_enabled)
  );
  host_link h (
    .clk(clk_sys),
    .cs(cs),
    .sclk(sclk),
    .din(din),
    .dout(serial_out),
    .oe_n(serial_out_oe_n)
  );
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ==========
  // checking
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic seen, input logic want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: saw %b want %b", $time, seen, want);
    end
  endtask
  task automatic note(input logic v);
    exp_q.push_back(v);
  endtask
  initial begin
    forever begin
      @(h.got);
      check(h.got_v, exp_q.pop_front());
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    $display("Error at %0t: watchdog ran out", $time);
    print_verdict();
  end
  // ==========
  // operations
  task automatic ext(input logic [1:0] code);
    h.cmd(32'({1'b1, OP_EXT, code, 4'h0}), 9);
  endtask
  task automatic rd(input logic [6:0] ad, input int an,
                    input logic [31:0] w, input int n);
    note(1'b0);
    for (int i = n - 1; i >= 0; i--) begin
      note(w[i]);
    end
    h.cmd(32'({1'b1, OP_READ}), 3);
    h.wt(20);
    h.cmd(32'(ad), an);
    h.rd(n);
    h.drop();
  endtask
  task automatic r16(input logic [5:0] ad);
    rd(7'(ad), 6, {mem[ad], mem[ad + 6'h1]}, 32);
  endtask
  task automatic prog(input bit st);
    h.drop();
    note(1'b1);
    h.see(busy);
    if (st) begin
      note(1'b0);
      note(1'b0);
      h.show();
    end else begin
      note(1'b1);
      h.see(serial_out_oe_n);
    end
    for (int i = 0; i < 200 && busy !== 1'b0; i++) h.wt(1);
    h.wt(3);
    if (st) begin
      note(1'b1);
      h.see(serial_out);
    end else begin
      note(1'b0);
      note(1'b1);
      h.show();
    end
    h.cmd(32'h1, 1);
    h.drop();
    note(1'b1);
    h.see(serial_out_oe_n);
  endtask
  // ==========
  // tests
  initial begin
    rst = 1'b1;
    width_select = 1'b1;
    num_errors = 0;
    checks_done = 0;
    seed = 32'h5A5D;
    repeat (3) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    h.wt(4);
    note(1'b0);
    h.see(program_enabled);
    note(1'b1);
    h.see(serial_out_oe_n);
    h.cmd(32'h0, 3);
    h.cmd(32'({1'b1, OP_WRITE, 6'h05, 16'h1234}), 25);
    h.drop();
    note(1'b0);
    h.see(busy);
    $display("test guard done");
    ext(EXT_ENABLE);
    h.drop();
    note(1'b1);
    h.see(program_enabled);
    ext(EXT_ERASE_ALL);
    prog(1'b1);
    foreach (mem[i]) mem[i] = 16'hFFFF;
    r16(6'h3F);
    $display("test erase all done");
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      a = seed[5:0];
      d = seed[31:16];
      h.cmd(32'({1'b1, OP_WRITE, a, d}), 25);
      prog(k[0]);
      mem[a] = d;
      r16(a);
    end
    $display("test write done");
    h.cmd(32'({1'b1, OP_ERASE, a}), 9);
    prog(1'b1);
    mem[a] = 16'hFFFF;
    r16(a);
    $display("test erase done");
    seed = xs(seed);
    d = seed[15:0];
    h.cmd(32'({1'b1, OP_EXT, EXT_WRITE_ALL, 4'h0, d}), 25);
    prog(1'b0);
    foreach (mem[i]) mem[i] = d;
    r16(6'h3F);
    $display("test write all done");
    ext(EXT_DISABLE);
    h.drop();
    note(1'b0);
    h.see(program_enabled);
    h.cmd(32'({1'b1, OP_ERASE, 6'h02}), 9);
    h.drop();
    note(1'b0);
    h.see(busy);
    r16(6'h02);
    width_select = 1'b0;
    rd(7'h00, 7, {16'h0, d}, 16);
    $display("test disable and width done");
    h.wt(4);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("Error at %0t: results missing", $time);
    end
    print_verdict();
  end
endmodule
